// [core/data_core_map.svh]
`ifndef DATA_CORE_MAP_SVH
`define DATA_CORE_MAP_SVH
// data memory addresses
`define ADDR_INDIRECT_0 8'h00
`define ADDR_RAM_PTR_0 8'h01
`define ADDR_INDIRECT_1 8'h02
`define ADDR_RAM_PTR_1 8'h03
`define ADDR_WORK 8'h05
`define ADDR_PC_LOW 8'h06
`define ADDR_TABLE_PTR 8'h07
`define ADDR_TABLE_HIGH 8'h08
`define ADDR_FLAGS 8'h0A
`define ADDR_RAM_BASE 8'h40
`define RAM_DEPTH 192
// status bit positions
`define FLAG_CARRY 0
`define FLAG_HALF 1
`define FLAG_ZERO 2
`define FLAG_WRAP 3
`define FLAG_HALT 4
`define FLAG_WDOG 5
`define FLAGS_SW_MASK 8'h0F
// table address and return stack
`define LAST_PAGE 4'hF
`define STACK_LEVELS 8
`define STACK_TOP 3'h0
`endif

// [core/data_core_pkg.sv]
package data_core_pkg;
  // alu operations
  typedef enum logic [3:0] {
    alu_pass, alu_add, alu_adc, alu_sub, alu_sbc, alu_daa, alu_and, alu_or,
    alu_xor, alu_cpl, alu_rl, alu_rr, alu_rlc, alu_rrc, alu_inc, alu_dec
  } alu_op_t;
  // table read sequencing
  typedef enum logic [1:0] {tbl_idle, tbl_fetch, tbl_store} tbl_state_t;
endpackage

// [core/data_core.sv]
`timescale 1ns/10ps
`default_nettype none
`include "data_core_map.svh"

module data_core (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  input wire logic alu_en,
  input wire data_core_pkg::alu_op_t alu_op,
  input wire logic alu_to_work,
  input wire logic bit_en,
  input wire logic bit_set,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] imm_data,
  input wire logic imm_en,
  input wire logic [11:0] pc_now,
  input wire logic call_push,
  input wire logic irq_push,
  input wire logic ret_pop,
  output logic [11:0] ret_addr,
  output logic stack_full,
  input wire logic irq_pending,
  output logic irq_ack_ok,
  input wire logic tbl_start,
  input wire logic tbl_last,
  input wire logic [7:0] tbl_dest,
  output logic tbl_busy,
  output logic [11:0] rom_addr,
  output logic rom_rd,
  input wire logic [14:0] rom_data,
  input wire logic halt_set,
  input wire logic wdog_clear,
  input wire logic wdog_timeout,
  output logic [11:0] pc_load_addr,
  output logic pc_load
);
  import data_core_pkg::*;

  // --------------------------------------------------
  // storage
  // --------------------------------------------------
  logic [7:0] ram_reg [`RAM_DEPTH]; // general purpose bytes
  logic [7:0] ram_pointer_0_reg; // first pointer
  logic [7:0] ram_pointer_1_reg; // second pointer
  logic [7:0] work_register_reg; // accumulator
  logic [7:0] table_pointer_reg; // table low address
  logic [6:0] table_high_latch_reg; // upper table bits
  logic [5:0] flag_reg; // status flags, bits 6-7 absent
  logic [11:0] stack_reg [`STACK_LEVELS]; // return addresses
  logic [2:0] stack_index_reg; // next free slot
  logic [3:0] stack_count_reg; // number of entries
  tbl_state_t tbl_state_reg; // table read phase
  tbl_state_t tbl_state_next;
  logic [7:0] tbl_dest_reg; // table destination address
  logic [11:0] rom_addr_reg; // latched table address
  logic [7:0] rdata_reg; // registered read data

  // --------------------------------------------------
  // address decode
  // --------------------------------------------------
  // resolve indirect ports to effective address
  function automatic logic [7:0] resolve(input logic [7:0] a, input logic [7:0] p0,
                                         input logic [7:0] p1);
    // 00H and 02H redirect through pointers
    if (a == `ADDR_INDIRECT_0) begin
      resolve = p0;
    end else if (a == `ADDR_INDIRECT_1) begin
      resolve = p1;
    end else begin
      resolve = a;
    end
  endfunction

  // one address per access, no port to port move
  // true when address is one of the indirect ports
  function automatic logic is_indirect(input logic [7:0] a);
    is_indirect = (a == `ADDR_INDIRECT_0) || (a == `ADDR_INDIRECT_1);
  endfunction

  logic [7:0] eff_addr; // resolved access address
  logic eff_dead; // pointer aims at an indirect port
  logic [7:0] cur_val; // current value at eff_addr
  logic [7:0] ram_idx; // ram index

  assign eff_addr = resolve(mem_addr, ram_pointer_0_reg, ram_pointer_1_reg);
  assign eff_dead = is_indirect(mem_addr) && is_indirect(eff_addr);
  assign ram_idx = eff_addr - `ADDR_RAM_BASE;

  // read mux for effective address
  always_comb begin
    cur_val = 8'h00;
    if (eff_dead) begin
      cur_val = 8'h00;
    end else if (eff_addr >= `ADDR_RAM_BASE) begin
      cur_val = ram_reg[ram_idx];
    end else begin
      unique case (eff_addr)
        `ADDR_RAM_PTR_0: cur_val = ram_pointer_0_reg;
        `ADDR_RAM_PTR_1: cur_val = ram_pointer_1_reg;
        `ADDR_WORK: cur_val = work_register_reg;
        `ADDR_PC_LOW: cur_val = pc_now[7:0];
        `ADDR_TABLE_PTR: cur_val = table_pointer_reg;
        `ADDR_TABLE_HIGH: cur_val = {1'b0, table_high_latch_reg};
        `ADDR_FLAGS: cur_val = {2'b00, flag_reg};
        default: cur_val = 8'h00;
      endcase
    end
  end

  // --------------------------------------------------
  // alu
  // --------------------------------------------------
  logic [7:0] alu_a; // operand from memory or immediate
  logic [7:0] alu_res; // result
  logic [8:0] sum9; // wide sum
  logic [4:0] half5; // nibble sum
  logic carry_out, half_out, wrap_out, flags_arith, flags_carry_only;
  logic cin;

  assign alu_a = imm_en ? imm_data : cur_val;
  assign cin = flag_reg[`FLAG_CARRY];

  always_comb begin
    sum9 = 9'h000;
    half5 = 5'h00;
    alu_res = alu_a;
    carry_out = cin;
    half_out = flag_reg[`FLAG_HALF];
    wrap_out = flag_reg[`FLAG_WRAP];
    flags_arith = 1'b0;
    flags_carry_only = 1'b0;
    unique case (alu_op)
      alu_pass: alu_res = alu_a;
      alu_add, alu_adc: begin
        sum9 = {1'b0, work_register_reg} + {1'b0, alu_a} + {8'h00, (alu_op == alu_adc) & cin};
        half5 = {1'b0, work_register_reg[3:0]} + {1'b0, alu_a[3:0]}
              + {4'h0, (alu_op == alu_adc) & cin};
        flags_arith = 1'b1;
      end
      alu_sub, alu_sbc: begin
        // carry set means no borrow
        sum9 = {1'b0, work_register_reg} + {1'b0, ~alu_a}
             + {8'h00, (alu_op == alu_sub) | cin};
        half5 = {1'b0, work_register_reg[3:0]} + {1'b0, ~alu_a[3:0]}
              + {4'h0, (alu_op == alu_sub) | cin};
        flags_arith = 1'b1;
      end
      alu_daa: begin
        // decimal correct the work register
        sum9 = {1'b0, work_register_reg};
        if (work_register_reg[3:0] > 4'h9 || flag_reg[`FLAG_HALF]) begin
          sum9 = sum9 + 9'h006;
        end
        if (sum9[7:4] > 4'h9 || cin || sum9[8]) begin
          sum9 = sum9 + 9'h060;
        end
        alu_res = sum9[7:0];
        carry_out = sum9[8] | cin;
        flags_carry_only = 1'b1;
      end
      alu_and: alu_res = work_register_reg & alu_a;
      alu_or: alu_res = work_register_reg | alu_a;
      alu_xor: alu_res = work_register_reg ^ alu_a;
      alu_cpl: alu_res = ~alu_a;
      alu_rl: alu_res = {alu_a[6:0], alu_a[7]};
      alu_rr: alu_res = {alu_a[0], alu_a[7:1]};
      alu_rlc: begin
        alu_res = {alu_a[6:0], cin};
        carry_out = alu_a[7];
        flags_carry_only = 1'b1;
      end
      alu_rrc: begin
        alu_res = {cin, alu_a[7:1]};
        carry_out = alu_a[0];
        flags_carry_only = 1'b1;
      end
      alu_inc: alu_res = alu_a + 8'h01;
      alu_dec: alu_res = alu_a - 8'h01;
    endcase
    if (flags_arith) begin
      alu_res = sum9[7:0];
      carry_out = sum9[8];
      half_out = half5[4];
      wrap_out = (work_register_reg[7] == (alu_op inside {alu_add, alu_adc} ? alu_a[7] : ~alu_a[7]))
               && (sum9[7] != work_register_reg[7]);
    end
  end

  // bit set and clear on any writable location
  logic [7:0] bit_res;
  always_comb begin
    bit_res = cur_val;
    bit_res[bit_sel] = bit_set;
  end

  // value written back to memory
  logic [7:0] store_val;
  logic store_mem;
  assign store_val = bit_en ? bit_res : (alu_en ? alu_res : mem_wdata);
  assign store_mem = (mem_wr || bit_en || (alu_en && !alu_to_work)) && !eff_dead;

  // --------------------------------------------------
  // table read
  // --------------------------------------------------
  logic tbl_write; // table store phase
  assign tbl_write = (tbl_state_reg == tbl_store);

  // table sequence state
  always_comb begin
    tbl_state_next = tbl_state_reg;
    unique case (tbl_state_reg)
      tbl_idle: if (tbl_start) tbl_state_next = tbl_fetch;
      tbl_fetch: tbl_state_next = tbl_store;
      tbl_store: tbl_state_next = tbl_idle;
      // spare state code returns to idle
      default: tbl_state_next = tbl_idle;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tbl_state_reg <= tbl_idle;
    end else begin
      tbl_state_reg <= tbl_state_next;
    end
  end

  // latch table address and destination
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rom_addr_reg <= 12'h000;
      tbl_dest_reg <= 8'h00;
    end else if (tbl_state_reg == tbl_idle && tbl_start) begin
      tbl_dest_reg <= tbl_dest;
      rom_addr_reg <= {tbl_last ? `LAST_PAGE : pc_now[11:8], table_pointer_reg};
    end
  end

  assign rom_addr = rom_addr_reg;
  assign rom_rd = (tbl_state_reg == tbl_fetch);
  assign tbl_busy = (tbl_state_reg != tbl_idle);

  // destination of table low byte
  logic [7:0] wr_addr;
  logic [7:0] wr_val;
  logic wr_en;
  logic [7:0] tbl_eff;
  assign tbl_eff = resolve(tbl_dest_reg, ram_pointer_0_reg, ram_pointer_1_reg);
  always_comb begin
    if (tbl_write) begin
      wr_addr = tbl_eff;
      wr_val = rom_data[7:0];
      wr_en = !(is_indirect(tbl_dest_reg) && is_indirect(tbl_eff));
    end else begin
      wr_addr = eff_addr;
      wr_val = store_val;
      wr_en = store_mem;
    end
  end

  // latch only loads on table read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      table_high_latch_reg <= 7'h00;
    end else if (tbl_write) begin
      table_high_latch_reg <= rom_data[14:8];
    end
  end

  // --------------------------------------------------
  // special registers and ram
  // --------------------------------------------------
  // ram storage
  genvar gi;
  generate
    for (gi = 0; gi < `RAM_DEPTH; gi++) begin : g_ram
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          ram_reg[gi] <= 8'h00;
        end else if (wr_en && wr_addr == 8'(gi + `ADDR_RAM_BASE)) begin
          ram_reg[gi] <= wr_val;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ram_pointer_0_reg <= 8'h00;
      ram_pointer_1_reg <= 8'h00;
      table_pointer_reg <= 8'h00;
    end else if (wr_en) begin
      if (wr_addr == `ADDR_RAM_PTR_0) ram_pointer_0_reg <= wr_val;
      if (wr_addr == `ADDR_RAM_PTR_1) ram_pointer_1_reg <= wr_val;
      if (wr_addr == `ADDR_TABLE_PTR) table_pointer_reg <= wr_val;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      work_register_reg <= 8'h00;
    end else if (alu_en && alu_to_work && !tbl_write) begin
      work_register_reg <= alu_res;
    end else if (wr_en && wr_addr == `ADDR_WORK) begin
      work_register_reg <= wr_val;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flag_reg <= 6'h00;
    end else begin
      if (wr_en && wr_addr == `ADDR_FLAGS) begin
        flag_reg[3:0] <= wr_val[3:0];
      end else if (alu_en && !tbl_write) begin
        flag_reg[`FLAG_ZERO] <= (alu_res == 8'h00);
        if (flags_arith || flags_carry_only) flag_reg[`FLAG_CARRY] <= carry_out;
        if (flags_arith) flag_reg[`FLAG_HALF] <= half_out;
        if (flags_arith) flag_reg[`FLAG_WRAP] <= wrap_out;
      end
      if (halt_set) begin
        flag_reg[`FLAG_HALT] <= 1'b1;
        flag_reg[`FLAG_WDOG] <= 1'b0;
      end else if (wdog_clear) begin
        flag_reg[`FLAG_HALT] <= 1'b0;
        flag_reg[`FLAG_WDOG] <= 1'b0;
      end
      if (wdog_timeout) flag_reg[`FLAG_WDOG] <= 1'b1;
    end
  end

  // short jump through program counter low
  assign pc_load = wr_en && wr_addr == `ADDR_PC_LOW;
  assign pc_load_addr = {pc_now[11:8], wr_val};

  // registered read data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (mem_rd) begin
      rdata_reg <= cur_val;
    end
  end
  assign mem_rdata = rdata_reg;

  // --------------------------------------------------
  // return stack
  // --------------------------------------------------
  logic do_push, do_pop;
  assign do_push = call_push || irq_push;
  assign do_pop = ret_pop && (stack_count_reg != 4'h0);
  assign stack_full = (stack_count_reg == 4'(`STACK_LEVELS));
  assign irq_ack_ok = irq_pending && !stack_full;
  assign ret_addr = stack_reg[3'(stack_index_reg - 3'h1)];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `STACK_LEVELS; i++) stack_reg[i] <= 12'h000;
    end else if (do_push) begin
      stack_reg[stack_index_reg] <= pc_now;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stack_index_reg <= `STACK_TOP;
      stack_count_reg <= 4'h0;
    end else if (do_push) begin
      stack_index_reg <= stack_index_reg + 3'h1;
      if (!stack_full) stack_count_reg <= stack_count_reg + 4'h1;
    end else if (do_pop) begin
      stack_index_reg <= stack_index_reg - 3'h1;
      stack_count_reg <= stack_count_reg - 4'h1;
    end
  end
endmodule
`default_nettype wire

// [test/data_core_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// port checker for the data core
// ----------------------------------------
module data_core_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic [11:0] pc_now,
  input wire logic call_push,
  input wire logic irq_push,
  input wire logic ret_pop,
  input wire logic [11:0] ret_addr,
  input wire logic stack_full,
  input wire logic irq_pending,
  input wire logic irq_ack_ok,
  input wire logic tbl_start,
  input wire logic tbl_last,
  input wire logic tbl_busy,
  input wire logic [11:0] rom_addr,
  input wire logic rom_rd,
  input wire logic [11:0] pc_load_addr,
  input wire logic pc_load
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // empty places in the low map
  logic rsv;
  assign rsv = (mem_addr inside {8'h04, 8'h09, 8'h0C}) || (mem_addr inside {[8'h0B:8'h3F]});
  // table read steps
  sequence s_go; tbl_start && !tbl_busy; endsequence
  sequence s_run; tbl_busy [*2] ##1 !tbl_busy; endsequence
  sequence s_fetch; rom_rd ##1 !rom_rd; endsequence
  property p_busy; s_go |=> s_run; endproperty
  a_busy: assert property (p_busy) else $error("table read length wrong");
  property p_fetch; s_go |=> s_fetch; endproperty
  a_fetch: assert property (p_fetch) else $error("program fetch strobe wrong");
  property p_page; s_go ##0 !tbl_last |=> (rom_addr >> 8) == ($past(pc_now) >> 8); endproperty
  a_page: assert property (p_page) else $error("current page address wrong");
  property p_last; s_go ##0 tbl_last |=> rom_addr[11:8] == 4'hF; endproperty
  a_last: assert property (p_last) else $error("last page address wrong");
  // stack and interrupt gate
  property p_ack; irq_ack_ok == (irq_pending && !stack_full); endproperty
  a_ack: assert property (p_ack) else $error("acknowledge gate wrong");
  property p_push; call_push || irq_push |=> ret_addr == $past(pc_now); endproperty
  a_push: assert property (p_push) else $error("pushed address lost");
  property p_full; stack_full && !ret_pop |=> stack_full; endproperty
  a_full: assert property (p_full) else $error("full stack dropped");
  // bus side effects
  property p_pcl;
    mem_wr && mem_addr == 8'h06 && !tbl_busy |-> pc_load && pc_load_addr == {pc_now[11:8], mem_wdata};
  endproperty
  a_pcl: assert property (p_pcl) else $error("short jump wrong");
  property p_rsv; mem_rd && rsv |=> mem_rdata == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("empty place not zero");
endmodule
bind data_core data_core_checker u_chk (.ref_clk, .rst, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
  .mem_rdata, .pc_now, .call_push, .irq_push, .ret_pop, .ret_addr, .stack_full, .irq_pending,
  .irq_ack_ok, .tbl_start, .tbl_last, .tbl_busy, .rom_addr, .rom_rd, .pc_load_addr, .pc_load);
`default_nettype wire

// [test/rom_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// program memory answer for table reads
// ----------------------------------------
module rom_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [11:0] rom_addr,
  input wire logic rom_rd,
  output logic [14:0] rom_data
);
  logic [14:0] word_reg; // fetched word
  logic valid_reg; // word shown this cycle
  // fetch on strobe, show it one cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      word_reg <= 15'h0000;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= rom_rd;
      if (rom_rd) begin
        word_reg <= {rom_addr[11:5] ^ 7'h2A, rom_addr[7:0] ^ 8'hC3};
      end
    end
  end
  // stale data inverted outside its cycle
  assign rom_data = valid_reg ? word_reg : ~word_reg;
endmodule
`default_nettype wire

// [test/data_core_tb.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// bench for the data core
// ----------------------------------------
module data_core_tb;
  import data_core_pkg::*;
  logic ref_clk, rst, mem_rd, mem_wr, alu_en, alu_to_work, bit_en, bit_set, imm_en;
  logic call_push, irq_push, ret_pop, irq_pending, tbl_start, tbl_last;
  logic halt_set, wdog_clear, wdog_timeout, stack_full, irq_ack_ok, tbl_busy, rom_rd, pc_load;
  logic [7:0] mem_addr, mem_wdata, mem_rdata, tbl_dest, imm_data, a;
  logic [2:0] bit_sel;
  logic [11:0] pc_now, ret_addr, rom_addr, pc_load_addr;
  logic [14:0] rom_data;
  alu_op_t alu_op;
  integer num_errors, check_count, seed, i;
  // reference model state
  logic [7:0] ram_m [256];
  logic [7:0] mp0_m, mp1_m, work_m, tp_m, th_m, st_m;
  logic [11:0] stk_q [$];
  logic [7:0] sfr_list [10] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h04, 8'h09, 8'h0C, 8'h3F};
  data_core u_dut (.ref_clk, .rst, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .alu_en,
    .alu_op, .alu_to_work, .bit_en, .bit_set, .bit_sel, .imm_data, .imm_en, .pc_now, .call_push,
    .irq_push, .ret_pop, .ret_addr, .stack_full, .irq_pending, .irq_ack_ok, .tbl_start, .tbl_last,
    .tbl_dest, .tbl_busy, .rom_addr, .rom_rd, .rom_data, .halt_set, .wdog_clear, .wdog_timeout,
    .pc_load_addr, .pc_load);
  rom_model u_rom (.ref_clk, .rst, .rom_addr, .rom_rd, .rom_data);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // model and helpers
  // ----------------------------------------
  function automatic logic [7:0] m_rd(input logic [7:0] x);
    case (x)
      8'h00: return (mp0_m == 8'h00 || mp0_m == 8'h02) ? 8'h00 : m_rd(mp0_m);
      8'h01: return mp0_m;
      8'h02: return (mp1_m == 8'h00 || mp1_m == 8'h02) ? 8'h00 : m_rd(mp1_m);
      8'h03: return mp1_m;
      8'h05: return work_m;
      8'h06: return pc_now[7:0];
      8'h07: return tp_m;
      8'h08: return th_m;
      8'h0A: return st_m;
      default: return (x >= 8'h40) ? ram_m[x] : 8'h00;
    endcase
  endfunction
  function automatic void m_wr(input logic [7:0] x, input logic [7:0] d);
    case (x)
      8'h00: if (mp0_m != 8'h00 && mp0_m != 8'h02) m_wr(mp0_m, d);
      8'h01: mp0_m = d;
      8'h02: if (mp1_m != 8'h00 && mp1_m != 8'h02) m_wr(mp1_m, d);
      8'h03: mp1_m = d;
      8'h05: work_m = d;
      8'h07: tp_m = d;
      8'h0A: st_m = (st_m & 8'h30) | (d & 8'h0F);
      default: if (x >= 8'h40) ram_m[x] = d;
    endcase
  endfunction
  // work register op with memory or immediate operand
  function automatic void m_alu(input alu_op_t op, input logic [7:0] b);
    logic [8:0] r;
    r = {1'b0, work_m} + {1'b0, b};
    case (op)
      alu_add: begin
        st_m[0] = r[8];
        st_m[1] = ({1'b0, work_m[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
        st_m[3] = (work_m[7] == b[7]) && (r[7] != work_m[7]);
      end
      // carry set means no borrow
      alu_sub: begin
        r = {1'b0, work_m} + {1'b0, ~b} + 9'h001;
        st_m[0] = r[8];
        st_m[1] = ({1'b0, work_m[3:0]} + {1'b0, ~b[3:0]} + 5'h01) > 5'h0F;
        st_m[3] = (work_m[7] != b[7]) && (r[7] != work_m[7]);
      end
      alu_and: r = {1'b0, work_m & b};
      alu_or: r = {1'b0, work_m | b};
      default: r = {1'b0, work_m ^ b};
    endcase
    work_m = r[7:0];
    st_m[2] = (r[7:0] == 8'h00);
  endfunction
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] gt);
    check_count++;
    if (gt !== ex) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, ex, gt);
    end
  endtask
  task automatic wr(input logic [7:0] x, input logic [7:0] d);
    @(posedge ref_clk);
    mem_addr <= x;
    mem_wdata <= d;
    mem_wr <= 1'b1;
    @(posedge ref_clk);
    mem_wr <= 1'b0;
    m_wr(x, d);
  endtask
  // read one place and compare with the model
  task automatic rd(input logic [7:0] x);
    @(posedge ref_clk);
    mem_addr <= x;
    mem_rd <= 1'b1;
    @(posedge ref_clk);
    mem_rd <= 1'b0;
    #1;
    chk("mem_rdata", {8'h00, m_rd(x)}, {8'h00, mem_rdata});
  endtask
  // one cycle strobe on a chosen input
  task automatic pulse(input int k);
    @(posedge ref_clk);
    case (k)
      0: call_push <= 1'b1;
      1: irq_push <= 1'b1;
      2: ret_pop <= 1'b1;
      3: halt_set <= 1'b1;
      4: wdog_clear <= 1'b1;
      5: wdog_timeout <= 1'b1;
      6: alu_en <= 1'b1;
      default: bit_en <= 1'b1;
    endcase
    @(posedge ref_clk);
    {call_push, irq_push, ret_pop, halt_set, wdog_clear, wdog_timeout, alu_en, bit_en} <= 8'h00;
    #1;
  endtask
  task automatic alu(input alu_op_t op, input logic [7:0] x);
    @(posedge ref_clk);
    alu_op <= op;
    mem_addr <= x;
    pulse(6);
    m_alu(op, imm_en ? imm_data : m_rd(x));
    rd(8'h05);
    rd(8'h0A);
  endtask
  task automatic tbl(input logic lst, input logic [7:0] dst);
    logic [11:0] ea;
    logic [14:0] w;
    int n;
    ea = {lst ? 4'hF : pc_now[11:8], tp_m};
    w = {ea[11:5] ^ 7'h2A, ea[7:0] ^ 8'hC3};
    @(posedge ref_clk);
    tbl_start <= 1'b1;
    tbl_last <= lst;
    tbl_dest <= dst;
    @(posedge ref_clk);
    tbl_start <= 1'b0;
    #1;
    chk("rom_addr", {4'h0, ea}, {4'h0, rom_addr});
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (tbl_busy !== 1'b0 && n < 8);
    chk("tbl_cycles", 16'h0002, 16'(n));
    if (n >= 8) tally_and_finish();
    m_wr(dst, w[7:0]);
    th_m = {1'b0, w[14:8]};
    rd(dst);
    rd(8'h08);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h350b0dc6;
    num_errors = 0;
    check_count = 0;
    rst = 1'b1;
    {mem_rd, mem_wr, alu_en, alu_to_work, bit_en, bit_set, imm_en, call_push} = 8'h00;
    {irq_push, ret_pop, irq_pending, tbl_start, tbl_last, halt_set, wdog_clear} = 7'h00;
    wdog_timeout = 1'b0;
    {mem_addr, mem_wdata, tbl_dest, imm_data} = 32'h0;
    bit_sel = 3'h0;
    pc_now = 12'h000;
    alu_op = alu_pass;
    {mp0_m, mp1_m, work_m, tp_m, th_m, st_m} = 48'h0;
    foreach (ram_m[j]) ram_m[j] = 8'h00;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values, then write and read back the low map
    for (i = 0; i < 10; i++) rd(sfr_list[i]);
    chk("stack_full", 16'h0, {15'h0, stack_full});
    for (i = 0; i < 10; i++) begin
      wr(sfr_list[i], 8'hA5 ^ 8'(i));
      rd(sfr_list[i]);
    end
    // general memory, both ends and random places
    for (i = 0; i < 12; i++) begin
      a = (i == 0) ? 8'h40 : (i == 1) ? 8'hFF : 8'h40 + 8'($unsigned($random(seed)) % 192);
      wr(a, 8'($random(seed)));
      rd(a);
    end
    // pointer access and a pointer aimed at the other indirect port
    wr(8'h01, 8'h50);
    wr(8'h00, 8'h3C);
    rd(8'h50);
    wr(8'h03, 8'h51);
    wr(8'h02, 8'hC3);
    rd(8'h51);
    rd(8'h02);
    wr(8'h01, 8'h02);
    wr(8'h00, 8'h77);
    rd(8'h00);
    rd(8'h51);
    // short jump through the low pc byte
    @(posedge ref_clk);
    pc_now <= 12'(($unsigned($random(seed)) % 4096));
    mem_addr <= 8'h06;
    mem_wdata <= 8'h9E;
    mem_wr <= 1'b1;
    #1;
    chk("pc_load", 16'h1, {15'h0, pc_load});
    chk("pc_load_addr", {4'h0, pc_now[11:8], 8'h9E}, {4'h0, pc_load_addr});
    @(posedge ref_clk);
    mem_wr <= 1'b0;
    rd(8'h06);
    // table reads, both pages, latch guarded
    wr(8'h07, 8'hFE);
    tbl(1'b0, 8'h60);
    wr(8'h07, 8'h00);
    tbl(1'b1, 8'h05);
    wr(8'h08, 8'h11);
    rd(8'h08);
    // status flags from halt, watchdog and writes
    pulse(3);
    st_m = (st_m & 8'hCF) | 8'h10;
    rd(8'h0A);
    pulse(5);
    st_m = st_m | 8'h20;
    rd(8'h0A);
    wr(8'h0A, 8'hFF);
    rd(8'h0A);
    pulse(4);
    st_m = st_m & 8'h0F;
    rd(8'h0A);
    // arithmetic and logic on memory operands
    alu_to_work <= 1'b1;
    wr(8'h05, 8'h7F);
    wr(8'h41, 8'h01);
    wr(8'h42, 8'h80);
    wr(8'h0A, 8'h00);
    alu(alu_add, 8'h41);
    alu(alu_xor, 8'h42);
    alu(alu_or, 8'h41);
    alu(alu_and, 8'h42);
    // immediate operand subtract
    imm_en <= 1'b1;
    imm_data <= 8'h30;
    alu(alu_sub, 8'h41);
    imm_en <= 1'b0;
    // single bit set and clear
    wr(8'h43, 8'hF0);
    for (i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      mem_addr <= 8'h43;
      bit_sel <= (i == 0) ? 3'h3 : 3'h7;
      bit_set <= (i == 0);
      pulse(7);
      ram_m[8'h43][(i == 0) ? 3 : 7] = (i == 0);
      rd(8'h43);
    end
    // nine pushes, oldest lost, pending interrupt held back
    irq_pending <= 1'b1;
    for (i = 0; i < 9; i++) begin
      @(posedge ref_clk);
      pc_now <= 12'h100 + 12'(i * 37);
      pulse(i % 2);
      stk_q.push_back(12'h100 + 12'(i * 37));
      if (stk_q.size() > 8) stk_q.pop_front();
    end
    chk("stack_full", 16'h1, {15'h0, stack_full});
    chk("irq_ack_ok", 16'h0, {15'h0, irq_ack_ok});
    for (i = 0; i < 8; i++) begin
      chk("ret_addr", {4'h0, stk_q[$]}, {4'h0, ret_addr});
      pulse(2);
      void'(stk_q.pop_back());
      chk("irq_ack_ok", 16'h1, {15'h0, irq_ack_ok});
    end
    chk("stack_full", 16'h0, {15'h0, stack_full});
    tally_and_finish();
  end
endmodule
`default_nettype wire
